// ---- design/pcyc_defs.vh ----
`ifndef PCYC_DEFS_VH
`define PCYC_DEFS_VH
// slots of a machine cycle, one oscillator period each, S1P1 = 0
`define PCYC_SLOTS 12
`define PCYC_SLOT_LAST 4'hB
`define PCYC_SLOT_S1P1 4'h0
`define PCYC_SLOT_S1P2 4'h1
`define PCYC_SLOT_S2P1 4'h2
`define PCYC_SLOT_S3P2 4'h5
`define PCYC_SLOT_S4P1 4'h6
`define PCYC_SLOT_S4P2 4'h7
`define PCYC_SLOT_S5P1 4'h8
`define PCYC_SLOT_S6P2 4'hB
// instruction lengths in machine cycles
`define PCYC_CYC_ONE 3'h1
`define PCYC_CYC_TWO 3'h2
`define PCYC_CYC_MULDIV 3'h4
// port latch reset value and bus ones
`define PCYC_PORT_RESET 8'hFF
// strong pull-up pulse length in oscillator periods
`define PCYC_STRONG_OSC 2
// port indices
`define PCYC_PORT_MUX 0
`define PCYC_PORT_ONE 1
`define PCYC_PORT_HIGH 2
`define PCYC_PORT_MULTI 3
`endif

// ---- design/pcyc_port.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pcyc_defs.vh"
module pcyc_port #(
	parameter WIDTH = 8,
	parameter HAS_PULLUP = 1
) (
	input wire clk_i,
	input wire reset_i,
	input wire phase1_i,
	input wire wr_i,
	input wire [WIDTH-1:0] wdata_i,
	input wire force_ones_i,
	input wire sel_latch_i,
	input wire [WIDTH-1:0] alt_out_i,
	input wire ovr_en_i,
	input wire [WIDTH-1:0] ovr_val_i,
	input wire ovr_pull_i,
	input wire [WIDTH-1:0] pin_i,
	output wire [WIDTH-1:0] latch_o,
	output wire [WIDTH-1:0] rd_val_o,
	output wire [WIDTH-1:0] pin_o,
	output wire [WIDTH-1:0] pin_oe_n_o,
	output wire [WIDTH-1:0] strong_o,
	output wire [WIDTH-1:0] keep_o,
	output wire [WIDTH-1:0] vweak_o,
	output wire [WIDTH-1:0] pdn_o
);
	reg [WIDTH-1:0] latch_q;
	reg [WIDTH-1:0] out_q;
	reg pull_q;
	reg [WIDTH-1:0] str_a_q;
	reg [WIDTH-1:0] str_b_q;
	reg [WIDTH-1:0] keep_q;
	wire [WIDTH-1:0] out_d;
	wire [WIDTH-1:0] rise;
	wire [WIDTH-1:0] pulse;

	////////////////////////////////////////////////////////////////
	// port latch: d flip-flops loaded from the internal bus
	always @(posedge clk_i) begin
		if (reset_i) begin
			latch_q <= `PCYC_PORT_RESET;
		end else if (force_ones_i) begin
			latch_q <= {WIDTH{1'b1}};
		end else if (wr_i) begin
			latch_q <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// output buffer reloads on the edge opening phase 1, holds in phase 2
	// so a latch value arriving in S6P2 reaches the pin at S1P1
	assign out_d = ovr_en_i ? ovr_val_i : (latch_q & alt_out_i);
	always @(posedge clk_i) begin
		if (reset_i) begin
			out_q <= `PCYC_PORT_RESET;
			pull_q <= 1'b0;
		end else if (!phase1_i) begin
			out_q <= out_d;
			pull_q <= ovr_en_i & ovr_pull_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// strong pull-up for two periods after a 0-to-1 change
	assign rise = (!phase1_i && !ovr_en_i) ? (~out_q & out_d) : {WIDTH{1'b0}};
	assign pulse = str_a_q | str_b_q;
	always @(posedge clk_i) begin
		if (reset_i) begin
			str_a_q <= {WIDTH{1'b0}};
			str_b_q <= {WIDTH{1'b0}};
			keep_q <= {WIDTH{1'b0}};
		end else begin
			str_a_q <= (HAS_PULLUP != 0) ? rise : {WIDTH{1'b0}};
			str_b_q <= str_a_q;
			keep_q <= (keep_q | pulse) & out_q & pin_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// drive enables and read paths
	assign strong_o = pulse | (pull_q ? out_q : {WIDTH{1'b0}});
	assign keep_o = keep_q;
	assign vweak_o = (HAS_PULLUP != 0) ? out_q : {WIDTH{1'b0}};
	assign pdn_o = ~out_q;
	assign pin_o = out_q;
	assign pin_oe_n_o = ~(~out_q | strong_o);
	assign latch_o = latch_q;
	assign rd_val_o = sel_latch_i ? latch_q : pin_i;
endmodule
`default_nettype wire

// ---- design/pcyc_seq.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pcyc_defs.vh"
module pcyc_seq (
	input wire clk_i,
	input wire reset_i,
	output wire [3:0] slot_o,
	output wire [2:0] state_o,
	output wire phase2_o,
	output wire cyc_end_o
);
	reg [3:0] slot_q;
	wire [3:0] slot_d;

	////////////////////////////////////////////////////////////////
	// slot counter, wraps after S6P2
	assign slot_d = (slot_q == `PCYC_SLOT_LAST) ? `PCYC_SLOT_S1P1 : slot_q + 4'h1;
	always @(posedge clk_i) begin
		if (reset_i) begin
			slot_q <= `PCYC_SLOT_S1P1;
		end else begin
			slot_q <= slot_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// phase bit toggles each period: internal clock at half rate
	assign phase2_o = slot_q[0];
	assign state_o = slot_q[3:1];
	assign slot_o = slot_q;
	assign cyc_end_o = (slot_q == `PCYC_SLOT_S6P2);
endmodule
`default_nettype wire

// ---- design/pcyc_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pcyc_defs.vh"
module pcyc_top (
	input wire clk_i,
	input wire reset_i,
	input wire [7:0] code_byte_i,
	input wire dec_two_byte_i,
	input wire [2:0] dec_cycles_i,
	input wire dec_muldiv_i,
	input wire dec_xdata_i,
	output reg code_fetch_o,
	output reg pc_inc_o,
	output reg [7:0] ir_o,
	output reg [7:0] operand_o,
	output reg exec_done_o,
	output wire [2:0] state_o,
	output wire phase2_o,
	output wire ale_o,
	input wire [15:0] xmove_addr_i,
	input wire xmove_wide_i,
	input wire xmove_write_i,
	input wire [7:0] xmove_wdata_i,
	output reg [7:0] xmove_rdata_o,
	output reg xmove_rvalid_o,
	input wire [3:0] port_wr_i,
	input wire [7:0] port_wdata_i,
	input wire [3:0] port_rd_latch_i,
	input wire [3:0] port_rd_pin_i,
	input wire rmw_i,
	output reg [7:0] port_rdata_o,
	input wire serial_tx_i,
	output wire serial_rx_o,
	output wire ext_irq_a_o,
	output wire ext_irq_b_o,
	output wire timer_a_count_in_o,
	output wire timer_b_count_in_o,
	output wire timer_c_count_in_o,
	output wire timer_c_trigger_in_o,
	input wire [7:0] mux_bus_port_in_i,
	output wire [7:0] mux_bus_port_out_o,
	output wire [7:0] mux_bus_port_oe_n_o,
	output wire [7:0] mux_bus_port_strong_o,
	output wire [7:0] mux_bus_port_keep_o,
	output wire [7:0] mux_bus_port_vweak_o,
	output wire [7:0] mux_bus_port_pdn_o,
	input wire [7:0] general_port_one_in_i,
	output wire [7:0] general_port_one_out_o,
	output wire [7:0] general_port_one_oe_n_o,
	output wire [7:0] general_port_one_strong_o,
	output wire [7:0] general_port_one_keep_o,
	output wire [7:0] general_port_one_vweak_o,
	output wire [7:0] general_port_one_pdn_o,
	input wire [7:0] high_address_port_in_i,
	output wire [7:0] high_address_port_out_o,
	output wire [7:0] high_address_port_oe_n_o,
	output wire [7:0] high_address_port_strong_o,
	output wire [7:0] high_address_port_keep_o,
	output wire [7:0] high_address_port_vweak_o,
	output wire [7:0] high_address_port_pdn_o,
	input wire [7:0] multifunction_port_in_i,
	output wire [7:0] multifunction_port_out_o,
	output wire [7:0] multifunction_port_oe_n_o,
	output wire [7:0] multifunction_port_strong_o,
	output wire [7:0] multifunction_port_keep_o,
	output wire [7:0] multifunction_port_vweak_o,
	output wire [7:0] multifunction_port_pdn_o
);
	wire [3:0] slot;
	wire cyc_end;
	reg first_q;
	reg two_byte_q;
	reg xdata_q;
	reg [2:0] ncyc_q;
	reg [2:0] cyc_cnt_q;
	wire xd_cyc2;
	wire addr_phase;
	wire data_phase;
	wire strobe_win;
	wire rd_n;
	wire wr_n;
	wire bus_start;
	wire [7:0] mux_ovr_val;
	wire [7:0] multi_alt;
	wire [7:0] rd_mux;
	wire [7:0] rd_one;
	wire [7:0] rd_high;
	wire [7:0] rd_multi;

	// strobe slots: S1P2, S2P1, S4P2, S5P1
	function ale_slot;
		input [3:0] s;
		begin
			ale_slot = (s == `PCYC_SLOT_S1P2) || (s == `PCYC_SLOT_S2P1) ||
				(s == `PCYC_SLOT_S4P2) || (s == `PCYC_SLOT_S5P1);
		end
	endfunction

	// cycle count of an instruction, clamped
	function [2:0] cyc_len;
		input [2:0] c;
		input md;
		input xd;
		begin
			if (md) begin
				cyc_len = `PCYC_CYC_MULDIV;
			end else if (xd || c >= `PCYC_CYC_TWO) begin
				cyc_len = `PCYC_CYC_TWO;
			end else begin
				cyc_len = `PCYC_CYC_ONE;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// state sequencer
	pcyc_seq u_seq (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.slot_o(slot),
		.state_o(state_o),
		.phase2_o(phase2_o),
		.cyc_end_o(cyc_end)
	);

	////////////////////////////////////////////////////////////////
	// instruction pacing: opcode, second byte, cycle count
	assign xd_cyc2 = xdata_q && (cyc_cnt_q == 3'h1);
	always @(posedge clk_i) begin
		if (reset_i) begin
			first_q <= 1'b1;
			two_byte_q <= 1'b0;
			xdata_q <= 1'b0;
			ncyc_q <= `PCYC_CYC_ONE;
			cyc_cnt_q <= 3'h0;
			ir_o <= 8'h00;
			operand_o <= 8'h00;
			code_fetch_o <= 1'b0;
			pc_inc_o <= 1'b0;
			exec_done_o <= 1'b0;
		end else begin
			code_fetch_o <= 1'b0;
			pc_inc_o <= 1'b0;
			exec_done_o <= 1'b0;
			if (slot == `PCYC_SLOT_S1P2 && !xd_cyc2) begin
				code_fetch_o <= 1'b1;
				if (first_q) begin
					ir_o <= code_byte_i;
					pc_inc_o <= 1'b1;
					two_byte_q <= dec_two_byte_i & ~dec_xdata_i;
					xdata_q <= dec_xdata_i;
					ncyc_q <= cyc_len(dec_cycles_i, dec_muldiv_i, dec_xdata_i);
					first_q <= 1'b0;
				end
			end
			if (slot == `PCYC_SLOT_S4P2 && !xd_cyc2) begin
				code_fetch_o <= 1'b1;
				if (cyc_cnt_q == 3'h0 && two_byte_q) begin
					operand_o <= code_byte_i;
					pc_inc_o <= 1'b1;
				end
			end
			if (cyc_end) begin
				if (cyc_cnt_q == ncyc_q - 3'h1) begin
					exec_done_o <= 1'b1;
					cyc_cnt_q <= 3'h0;
					first_q <= 1'b1;
					xdata_q <= 1'b0;
					two_byte_q <= 1'b0;
				end else begin
					cyc_cnt_q <= cyc_cnt_q + 3'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// address latch strobe, first pulse dropped in data move cycle two
	assign ale_o = ale_slot(slot) && !(xd_cyc2 && slot < `PCYC_SLOT_S4P2);

	////////////////////////////////////////////////////////////////
	// external data access windows and strobes
	assign addr_phase = xdata_q && cyc_cnt_q == 3'h0 && slot >= `PCYC_SLOT_S4P2;
	assign data_phase = xd_cyc2 && slot <= `PCYC_SLOT_S4P1;
	assign strobe_win = data_phase && slot >= `PCYC_SLOT_S1P2 && slot <= `PCYC_SLOT_S3P2;
	assign rd_n = ~(strobe_win & ~xmove_write_i);
	assign wr_n = ~(strobe_win & xmove_write_i);
	assign bus_start = xdata_q && cyc_cnt_q == 3'h0 && slot == `PCYC_SLOT_S4P2;
	assign mux_ovr_val = addr_phase ? xmove_addr_i[7:0] :
		(xmove_write_i ? xmove_wdata_i : 8'hFF);

	// read data taken at S3P2 from the bus port pins
	always @(posedge clk_i) begin
		if (reset_i) begin
			xmove_rdata_o <= 8'h00;
			xmove_rvalid_o <= 1'b0;
		end else begin
			xmove_rvalid_o <= 1'b0;
			if (data_phase && !xmove_write_i && slot == `PCYC_SLOT_S3P2) begin
				xmove_rdata_o <= mux_bus_port_in_i;
				xmove_rvalid_o <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// alternate functions
	assign multi_alt = {rd_n, wr_n, 4'hF, serial_tx_i, 1'b1};
	assign serial_rx_o = multifunction_port_in_i[0];
	assign ext_irq_a_o = multifunction_port_in_i[2];
	assign ext_irq_b_o = multifunction_port_in_i[3];
	assign timer_a_count_in_o = multifunction_port_in_i[4];
	assign timer_b_count_in_o = multifunction_port_in_i[5];
	assign timer_c_count_in_o = general_port_one_in_i[0];
	assign timer_c_trigger_in_o = general_port_one_in_i[1];

	////////////////////////////////////////////////////////////////
	// port units
	pcyc_port #(.WIDTH(8), .HAS_PULLUP(0)) u_mux (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.phase1_i(~phase2_o),
		.wr_i(port_wr_i[`PCYC_PORT_MUX]),
		.wdata_i(port_wdata_i),
		.force_ones_i(bus_start),
		.sel_latch_i(port_rd_latch_i[`PCYC_PORT_MUX] | rmw_i),
		.alt_out_i(8'hFF),
		.ovr_en_i(addr_phase | data_phase),
		.ovr_val_i(mux_ovr_val),
		.ovr_pull_i(addr_phase | xmove_write_i),
		.pin_i(mux_bus_port_in_i),
		.latch_o(),
		.rd_val_o(rd_mux),
		.pin_o(mux_bus_port_out_o),
		.pin_oe_n_o(mux_bus_port_oe_n_o),
		.strong_o(mux_bus_port_strong_o),
		.keep_o(mux_bus_port_keep_o),
		.vweak_o(mux_bus_port_vweak_o),
		.pdn_o(mux_bus_port_pdn_o)
	);

	pcyc_port #(.WIDTH(8), .HAS_PULLUP(1)) u_one (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.phase1_i(~phase2_o),
		.wr_i(port_wr_i[`PCYC_PORT_ONE]),
		.wdata_i(port_wdata_i),
		.force_ones_i(1'b0),
		.sel_latch_i(port_rd_latch_i[`PCYC_PORT_ONE] | rmw_i),
		.alt_out_i(8'hFF),
		.ovr_en_i(1'b0),
		.ovr_val_i(8'hFF),
		.ovr_pull_i(1'b0),
		.pin_i(general_port_one_in_i),
		.latch_o(),
		.rd_val_o(rd_one),
		.pin_o(general_port_one_out_o),
		.pin_oe_n_o(general_port_one_oe_n_o),
		.strong_o(general_port_one_strong_o),
		.keep_o(general_port_one_keep_o),
		.vweak_o(general_port_one_vweak_o),
		.pdn_o(general_port_one_pdn_o)
	);

	pcyc_port #(.WIDTH(8), .HAS_PULLUP(1)) u_high (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.phase1_i(~phase2_o),
		.wr_i(port_wr_i[`PCYC_PORT_HIGH]),
		.wdata_i(port_wdata_i),
		.force_ones_i(1'b0),
		.sel_latch_i(port_rd_latch_i[`PCYC_PORT_HIGH] | rmw_i),
		.alt_out_i(8'hFF),
		.ovr_en_i((addr_phase | data_phase) & xmove_wide_i),
		.ovr_val_i(xmove_addr_i[15:8]),
		.ovr_pull_i(1'b1),
		.pin_i(high_address_port_in_i),
		.latch_o(),
		.rd_val_o(rd_high),
		.pin_o(high_address_port_out_o),
		.pin_oe_n_o(high_address_port_oe_n_o),
		.strong_o(high_address_port_strong_o),
		.keep_o(high_address_port_keep_o),
		.vweak_o(high_address_port_vweak_o),
		.pdn_o(high_address_port_pdn_o)
	);

	pcyc_port #(.WIDTH(8), .HAS_PULLUP(1)) u_multi (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.phase1_i(~phase2_o),
		.wr_i(port_wr_i[`PCYC_PORT_MULTI]),
		.wdata_i(port_wdata_i),
		.force_ones_i(1'b0),
		.sel_latch_i(port_rd_latch_i[`PCYC_PORT_MULTI] | rmw_i),
		.alt_out_i(multi_alt),
		.ovr_en_i(1'b0),
		.ovr_val_i(8'hFF),
		.ovr_pull_i(1'b0),
		.pin_i(multifunction_port_in_i),
		.latch_o(),
		.rd_val_o(rd_multi),
		.pin_o(multifunction_port_out_o),
		.pin_oe_n_o(multifunction_port_oe_n_o),
		.strong_o(multifunction_port_strong_o),
		.keep_o(multifunction_port_keep_o),
		.vweak_o(multifunction_port_vweak_o),
		.pdn_o(multifunction_port_pdn_o)
	);

	////////////////////////////////////////////////////////////////
	// register read data, latch path forced for read-modify-write
	always @(posedge clk_i) begin
		if (reset_i) begin
			port_rdata_o <= 8'h00;
		end else if (port_rd_latch_i[0] | port_rd_pin_i[0]) begin
			port_rdata_o <= rd_mux;
		end else if (port_rd_latch_i[1] | port_rd_pin_i[1]) begin
			port_rdata_o <= rd_one;
		end else if (port_rd_latch_i[2] | port_rd_pin_i[2]) begin
			port_rdata_o <= rd_high;
		end else if (port_rd_latch_i[3] | port_rd_pin_i[3]) begin
			port_rdata_o <= rd_multi;
		end
	end
endmodule
`default_nettype wire

// ---- dv/pcyc_ext_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcyc_ext_mem (
	input wire logic clk_i,
	input wire logic ale_i,
	input wire logic [7:0] mux_i,
	input wire logic [7:0] mux_oe_n_i,
	input wire logic [7:0] one_i,
	input wire logic [7:0] one_oe_n_i,
	input wire logic [7:0] high_i,
	input wire logic [7:0] high_oe_n_i,
	input wire logic [7:0] multi_i,
	input wire logic [7:0] multi_oe_n_i,
	input wire logic [7:0] one_low_i,
	input wire logic [7:0] multi_low_i,
	output logic [7:0] mux_pin_o,
	output logic [7:0] one_pin_o,
	output logic [7:0] high_pin_o,
	output logic [7:0] multi_pin_o,
	output logic [15:0] seen_o
);
	logic [7:0] mem_q [0:255];
	logic [15:0] alat_q;
	logic [7:0] last_q;
	// pulled-up pins read high unless held low from outside
	assign one_pin_o = (one_oe_n_i & ~one_low_i) | (~one_oe_n_i & one_i);
	assign multi_pin_o = (multi_oe_n_i & ~multi_low_i) | (~multi_oe_n_i & multi_i);
	assign high_pin_o = high_oe_n_i | high_i;
	// released bus shows no stale value; memory drives it while read strobe is low
	assign mux_pin_o = (~mux_oe_n_i & mux_i) | (mux_oe_n_i &
		(multi_pin_o[7] ? ~last_q : mem_q[alat_q[7:0]]));
	// address latch follows the strobe, memory writes while write strobe is low
	always @(posedge clk_i) begin
		last_q <= mux_pin_o;
		if (ale_i)
			alat_q <= {high_pin_o, mux_pin_o};
		if (!multi_pin_o[6])
			mem_q[alat_q[7:0]] <= mux_pin_o;
		if (!multi_pin_o[6] || !multi_pin_o[7])
			seen_o <= alat_q;
	end
endmodule
`default_nettype wire

// ---- dv/pcyc_top_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcyc_top_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [2:0] state_o,
	input wire logic phase2_o,
	input wire logic ale_o,
	input wire logic code_fetch_o,
	input wire logic exec_done_o,
	input wire logic [7:0] general_port_one_out_o,
	input wire logic [7:0] general_port_one_strong_o,
	input wire logic [7:0] general_port_one_vweak_o,
	input wire logic [7:0] general_port_one_pdn_o
);
	wire [3:0] slot;
	// slot number is the state index with the phase bit appended
	assign slot = {state_o, phase2_o};
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	AST_PHASE_TOGGLE: assert property (!$past(reset_i, 2) && !$past(reset_i) |->
		phase2_o != $past(phase2_o)) else $error("phase did not alternate");
	AST_STATE_STEP: assert property (!$past(reset_i) && $past(phase2_o) |->
		state_o == (($past(state_o) == 3'h5) ? 3'h0 : $past(state_o) + 3'h1))
		else $error("state did not advance");
	AST_ALE_QUIET: assert property (!(slot inside {4'h1, 4'h2, 4'h7, 4'h8}) |-> !ale_o)
		else $error("strobe outside its slots");
	AST_ALE_SECOND: assert property (slot == 4'h7 |-> ale_o ##1 ale_o ##1 !ale_o)
		else $error("second strobe wrong");
	AST_FETCH_SLOT: assert property (code_fetch_o |-> ale_o && (slot == 4'h2 || slot == 4'h8))
		else $error("fetch outside strobe slots");
	AST_DONE_SLOT: assert property (exec_done_o |-> slot == 4'h0)
		else $error("done not at cycle start");
	AST_PIN_HOLD: assert property ($changed(general_port_one_out_o) |=>
		$stable(general_port_one_out_o)) else $error("pin changed in hold phase");
	AST_RESET_ONES: assert property ($fell(reset_i) |->
		general_port_one_out_o == 8'hFF && general_port_one_pdn_o == 8'h00)
		else $error("port not ones after reset");
	AST_STRONG_TWO: assert property ($rose(general_port_one_strong_o[0]) |=>
		general_port_one_strong_o[0] ##1 !general_port_one_strong_o[0])
		else $error("strong pulse length wrong");
	AST_DRIVE_SPLIT: assert property (general_port_one_pdn_o == ~general_port_one_out_o
		&& general_port_one_vweak_o == ~general_port_one_pdn_o) else $error("drive enables wrong");
	AST_PIN_PHASE1: assert property ($changed(general_port_one_out_o) |-> !phase2_o)
		else $error("pin changed outside phase one");
	AST_STRONG_PHASE: assert property ($rose(general_port_one_strong_o[0]) |-> !phase2_o)
		else $error("strong pulse began in phase two");
endmodule
bind pcyc_top pcyc_top_monitor u_mon (.*);
`default_nettype wire

// ---- dv/pcyc_top_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcyc_top_tb_top;
	logic clk_i, reset_i, dec_two_byte_i, dec_muldiv_i, dec_xdata_i, xmove_wide_i, xmove_write_i;
	logic rmw_i, serial_tx_i;
	logic [2:0] dec_cycles_i;
	logic [3:0] port_wr_i, port_rd_latch_i, port_rd_pin_i;
	logic [7:0] code_byte_i, xmove_wdata_i, port_wdata_i, one_low, multi_low;
	logic [15:0] xmove_addr_i;
	wire code_fetch_o, pc_inc_o, exec_done_o, phase2_o, ale_o, xmove_rvalid_o, serial_rx_o;
	wire ext_irq_a_o, ext_irq_b_o, timer_a_count_in_o, timer_b_count_in_o, timer_c_count_in_o;
	wire timer_c_trigger_in_o;
	wire [2:0] state_o;
	wire [15:0] seen;
	wire [7:0] ir_o, operand_o, xmove_rdata_o, port_rdata_o;
	wire [7:0] mux_bus_port_in_i, mux_bus_port_out_o, mux_bus_port_oe_n_o, mux_bus_port_strong_o;
	wire [7:0] mux_bus_port_keep_o, mux_bus_port_vweak_o, mux_bus_port_pdn_o;
	wire [7:0] general_port_one_in_i, general_port_one_out_o, general_port_one_oe_n_o;
	wire [7:0] general_port_one_strong_o, general_port_one_keep_o, general_port_one_vweak_o;
	wire [7:0] general_port_one_pdn_o, high_address_port_in_i, high_address_port_out_o;
	wire [7:0] high_address_port_oe_n_o, high_address_port_strong_o, high_address_port_keep_o;
	wire [7:0] high_address_port_vweak_o, high_address_port_pdn_o, multifunction_port_in_i;
	wire [7:0] multifunction_port_out_o, multifunction_port_oe_n_o, multifunction_port_strong_o;
	wire [7:0] multifunction_port_keep_o, multifunction_port_vweak_o, multifunction_port_pdn_o;
	int n_mismatch, num_checks, n_rv;
	logic [7:0] exp_opnd = 8'h00, rd_last = 8'h00;
	pcyc_top DUT (.*);
	pcyc_ext_mem u_ext (.clk_i(clk_i), .ale_i(ale_o), .mux_i(mux_bus_port_out_o),
		.mux_oe_n_i(mux_bus_port_oe_n_o), .one_i(general_port_one_out_o),
		.one_oe_n_i(general_port_one_oe_n_o), .high_i(high_address_port_out_o),
		.high_oe_n_i(high_address_port_oe_n_o), .multi_i(multifunction_port_out_o),
		.multi_oe_n_i(multifunction_port_oe_n_o), .one_low_i(one_low), .multi_low_i(multi_low),
		.mux_pin_o(mux_bus_port_in_i), .one_pin_o(general_port_one_in_i),
		.high_pin_o(high_address_port_in_i), .multi_pin_o(multifunction_port_in_i), .seen_o(seen));
	// oscillator
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// read-valid pulses seen since reset
	always @(posedge clk_i) begin
		if (!reset_i && xmove_rvalid_o === 1'b1)
			n_rv <= n_rv + 1;
	end
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chki(input string nm, input integer e, input integer s);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bounded step until the sequencer sits in slot k
	task automatic to_slot(input int k);
		for (int i = 0; i < 30; i++) begin
			@(posedge clk_i);
			#1;
			if ({state_o, phase2_o} === k[3:0])
				return;
		end
		chki("slot reached", k, -1);
		give_verdict;
	endtask
	// return at the edge that opens slot k
	task automatic at_slot(input int k);
		to_slot((k + 11) % 12);
		@(posedge clk_i);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic t_cycle;
		integer n = 0, a = 0, p = 0;
		to_slot(0);
		do begin
			@(posedge clk_i);
			#1;
			n++;
			a += ale_o;
			p += phase2_o;
		end while ({state_o, phase2_o} !== 4'h0 && n < 30);
		chki("cycle length", 12, n);
		chki("strobe slots", 4, a);
		chki("phase two slots", 6, p);
		if (n >= 30)
			give_verdict;
	endtask
	task automatic t_instr(input logic [7:0] op, input logic [7:0] b2, input logic two,
		input logic [2:0] cyc, input logic md, input logic xd, input int len, input int nf,
		input int ni, input int na);
		integer n = 0, f = 0, c = 0, a = 0;
		at_slot(1);
		code_byte_i <= op;
		dec_two_byte_i <= two;
		dec_cycles_i <= cyc;
		dec_muldiv_i <= md;
		dec_xdata_i <= xd;
		@(posedge clk_i);
		code_byte_i <= b2;
		dec_two_byte_i <= 1'b0;
		dec_cycles_i <= 3'h1;
		dec_muldiv_i <= 1'b0;
		dec_xdata_i <= 1'b0;
		#1;
		while (exec_done_o !== 1'b1 && n < 60) begin
			f += code_fetch_o;
			c += pc_inc_o;
			a += ale_o;
			@(posedge clk_i);
			#1;
			n++;
		end
		chk8("opcode", op, ir_o);
		chk8("second byte", two ? b2 : exp_opnd, operand_o);
		if (two)
			exp_opnd = b2;
		chki("length", len, n);
		chki("fetches", nf, f);
		chki("pc steps", ni, c);
		chki("strobes", na, a);
		if (n >= 60)
			give_verdict;
	endtask
	task automatic t_xmove(input logic [15:0] ad, input logic wide, input logic wr,
		input logic [7:0] d, input logic [15:0] es);
		int r0;
		@(posedge clk_i);
		xmove_addr_i <= ad;
		xmove_wide_i <= wide;
		xmove_write_i <= wr;
		xmove_wdata_i <= d;
		r0 = n_rv;
		t_instr(8'hE0, 8'h00, 1'b0, 3'h2, 1'b0, 1'b1, 22, 2, 1, 5);
		chk8("addr high", es[15:8], seen[15:8]);
		chk8("addr low", es[7:0], seen[7:0]);
		chk8("read data", wr ? rd_last : d, xmove_rdata_o);
		chki("read valid pulses", wr ? 0 : 1, n_rv - r0);
		if (!wr)
			rd_last = d;
	endtask
	task automatic port_wr(input int p, input logic [7:0] v);
		at_slot(10);
		port_wr_i <= 4'h1 << p;
		port_wdata_i <= v;
		@(posedge clk_i);
		port_wr_i <= 4'h0;
	endtask
	task automatic port_rd(input logic [3:0] l, input logic [3:0] pn, input logic m,
		input logic [7:0] e, input string nm);
		@(posedge clk_i);
		port_rd_latch_i <= l;
		port_rd_pin_i <= pn;
		rmw_i <= m;
		@(posedge clk_i);
		port_rd_latch_i <= 4'h0;
		port_rd_pin_i <= 4'h0;
		rmw_i <= 1'b0;
		#1;
		chk8(nm, e, port_rdata_o);
	endtask
	task automatic t_io;
		int s = 0;
		@(posedge clk_i);
		one_low <= 8'h03;
		port_rd(4'h2, 4'h0, 1'b0, 8'hFF, "latch read");
		port_rd(4'h0, 4'h2, 1'b0, 8'hFC, "pin read");
		port_rd(4'h0, 4'h2, 1'b1, 8'hFF, "rmw read");
		chk8("timer c pins", 8'h00, {6'h0, timer_c_trigger_in_o, timer_c_count_in_o});
		@(posedge clk_i);
		one_low <= 8'h00;
		port_wr(1, 8'h00);
		#1;
		chk8("pin in S6P2", 8'hFF, general_port_one_out_o);
		@(posedge clk_i);
		#1;
		chk8("pin at S1P1", 8'h00, general_port_one_out_o);
		settle;
		chk8("port one pins", 8'h00, general_port_one_out_o);
		chk8("port one pulldown", 8'hFF, general_port_one_pdn_o);
		port_wr(1, 8'hFF);
		repeat (8) begin
			@(posedge clk_i);
			#1;
			s += general_port_one_strong_o[0];
		end
		chki("strong periods", 2, s);
		chk8("keeper", 8'hFF, general_port_one_keep_o);
	endtask
	task automatic t_alt;
		@(posedge clk_i);
		serial_tx_i <= 1'b0;
		multi_low <= 8'h04;
		settle;
		chk8("tx pin", 8'h00, {7'h0, multifunction_port_out_o[1]});
		chk8("irq pin", 8'h00, {7'h0, ext_irq_a_o});
		chk8("alt inputs", 8'h1D, {3'h0, timer_b_count_in_o, timer_a_count_in_o, ext_irq_b_o,
			ext_irq_a_o, serial_rx_o});
		port_wr(3, 8'hFD);
		@(posedge clk_i);
		serial_tx_i <= 1'b1;
		settle;
		chk8("tx stuck", 8'h00, {7'h0, multifunction_port_out_o[1]});
		port_wr(3, 8'hFF);
		settle;
		chk8("tx follows", 8'h01, {7'h0, multifunction_port_out_o[1]});
	endtask
	task automatic t_mux;
		chk8("bus floats", 8'hFF, mux_bus_port_oe_n_o);
		port_wr(0, 8'h00);
		settle;
		chk8("bus pulldown", 8'hFF, mux_bus_port_pdn_o);
		port_wr(2, 8'h3C);
		t_xmove(16'h12AB, 1'b1, 1'b1, 8'h5A, 16'h12AB);
		port_rd(4'h1, 4'h0, 1'b0, 8'hFF, "bus latch");
		port_rd(4'h4, 4'h0, 1'b0, 8'h3C, "high latch");
		t_xmove(16'h77AB, 1'b0, 1'b0, 8'h5A, 16'h3CAB);
	endtask
	// main sequence
	initial begin
		{reset_i, serial_tx_i, dec_cycles_i} = 5'h19;
		{dec_two_byte_i, dec_muldiv_i, dec_xdata_i, xmove_wide_i, xmove_write_i, rmw_i} = 6'h00;
		{port_wr_i, port_rd_latch_i, port_rd_pin_i} = 12'h000;
		{code_byte_i, xmove_wdata_i, port_wdata_i, one_low, multi_low} = 40'h0;
		xmove_addr_i = 16'h0000;
		repeat (15) @(posedge clk_i);
		#1;
		chk8("reset slot", 8'h00, {4'h0, state_o, phase2_o});
		@(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		chk8("bus reset", 8'hFF, mux_bus_port_out_o);
		chk8("one reset", 8'hFF, general_port_one_out_o);
		chk8("high reset", 8'hFF, high_address_port_out_o);
		chk8("multi reset", 8'hFF, multifunction_port_out_o);
		t_cycle;
		t_instr(8'h04, 8'h00, 1'b0, 3'h1, 1'b0, 1'b0, 10, 2, 1, 3);
		t_instr(8'h24, 8'h31, 1'b1, 3'h1, 1'b0, 1'b0, 10, 2, 2, 3);
		t_instr(8'hA3, 8'h00, 1'b0, 3'h2, 1'b0, 1'b0, 22, 4, 1, 7);
		t_instr(8'hA4, 8'h00, 1'b0, 3'h4, 1'b1, 1'b0, 46, 8, 1, 15);
		t_instr(8'hA5, 8'h00, 1'b0, 3'h7, 1'b0, 1'b0, 22, 4, 1, 7);
		t_io;
		t_alt;
		t_mux;
		give_verdict;
	end
endmodule
`default_nettype wire
